// ==== hdl/dwbtc_top.sv ====
// The Avalon-MM register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module dwbtc_top
  import dwbtc_pkg::*;
(
  input wire logic sys_clk_i, // 100 MHz clock
  input wire logic sys_rst_i, // async reset, active high
  input wire logic [1:0] avs_address_i, // register word index
  input wire logic avs_read_i, // avalon read
  input wire logic avs_write_i, // avalon write
  input wire logic [31:0] avs_writedata_i, // avalon write data
  input wire logic [3:0] avs_byteenable_i, // avalon byte lanes
  output logic [31:0] avs_readdata_o, // avalon read data
  output logic avs_waitrequest_o, // avalon stall
  input wire logic delayed_write_clock_i, // transfer timing clock level
  input wire logic subsector_start_i, // pulse, new subsector begins
  input wire logic write_sequence_go_i, // pulse, serializer may start
  input wire logic shift_pulse_i, // pulse, one bit passes the head
  input wire logic read_bit_i, // bit read from disc
  input wire logic check_word_cycle_i, // check word being sent
  input wire logic parity_bit_cycle_i, // parity bit being sent
  input wire logic subsector_end_interval_i, // end one-shot running
  output logic write_data_o, // serial bit to the disc
  output logic buffer_load_from_processor_n_o, // write load strobe
  output logic register_set_from_buffer_n_o, // read register strobe
  output logic data_register_set_o, // data register loaded
  output logic buffer_load_n_o, // any word written to buffer
  output logic shift_register_load_o, // serializer loaded
  output logic buffer_full_o, // sixteen words held
  output logic buffer_full_n_o, // full, active low
  output logic buffer_empty_n_o, // empty, active low
  output logic register_full_flag_o, // data register occupied
  output logic strobe_inhibit_n_o // strobes held off, active low
);
  logic [15:0] mem_q [16];
  logic [3:0] wr_ptr_q, rd_ptr_q, bits_q;
  logic [4:0] cnt_q;
  logic [15:0] data_q, sr_q;
  logic write_op_q, read_op_q, diag_q;
  logic reg_full_q, ack_q, started_q;
  logic dwc_q, half_q, permit_q;
  logic bflp_q, rsfb_q, drs_q, buffer_load_n_q, shift_register_load_q, wdat_q;
  logic [31:0] rdata_q;
  logic req, ok, acc, init, dat_wr, dat_rd, dwc_rise;
  logic data_shift, last_bit, inhib, bitwin, go_wr, go_rd;
  logic inc, dec, do_shift_register_load, deser_ld, empty, full;
  logic [15:0] deser_word, crc;
  logic parity;

  function automatic logic [3:0] ptr_next(input logic [3:0] p);
    ptr_next = p + 4'h1;
  endfunction : ptr_next

  // avalon handshake: stall until ok, at least one cycle, then one acknowledge cycle
  assign req = avs_read_i | avs_write_i;
  always_comb begin
    ok = 1'b1;
    if (avs_address_i == ADDR_DATA && avs_write_i) begin
      ok = !reg_full_q || !write_op_q; // back-pressure on the processor
    end else if (avs_address_i == ADDR_DATA && avs_read_i) begin
      ok = reg_full_q || !read_op_q;
    end
  end
  assign acc = req & ack_q;
  assign init = acc & avs_write_i & (avs_address_i == ADDR_CTRL)
                & avs_byteenable_i[0];
  assign dat_wr = acc & avs_write_i & (avs_address_i == ADDR_DATA)
                  & (avs_byteenable_i[1:0] != 2'h0) & write_op_q;
  assign dat_rd = acc & avs_read_i & (avs_address_i == ADDR_DATA)
                  & read_op_q;
  assign empty = ~cnt_q[4];
  assign full = (cnt_q == CNT_FULL);

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q & ok;
    end
  end

  // read data captured as the acknowledge rises, held through it
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (req && !ack_q && ok && avs_read_i) begin
      rdata_q <= 32'h0000_0000;
      if (avs_address_i == ADDR_CTRL) begin
        rdata_q[CTRL_WRITE_OP] <= write_op_q;
        rdata_q[CTRL_READ_OP] <= read_op_q;
        rdata_q[CTRL_DIAG_SEL] <= diag_q;
      end else if (avs_address_i == ADDR_STAT) begin
        rdata_q[STAT_CNT_LSB +: 5] <= cnt_q;
        rdata_q[STAT_FULL] <= full;
        rdata_q[STAT_EMPTY] <= empty;
        rdata_q[STAT_REG_FULL] <= reg_full_q;
      end else if (avs_address_i == ADDR_DATA) begin
        rdata_q[15:0] <= data_q;
      end else begin
        rdata_q[15:0] <= crc;
      end
    end
  end

  // mode register; any control write with byte lane 0 enabled also initialises the block
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      write_op_q <= 1'b0;
      read_op_q <= 1'b0;
      diag_q <= 1'b0;
    end else if (init) begin
      write_op_q <= avs_writedata_i[CTRL_WRITE_OP];
      read_op_q <= avs_writedata_i[CTRL_READ_OP]
                   & ~avs_writedata_i[CTRL_WRITE_OP];
      diag_q <= avs_writedata_i[CTRL_DIAG_SEL];
    end
  end

  // transfer permit: every second rise of the delayed write clock
  assign dwc_rise = delayed_write_clock_i & ~dwc_q;
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dwc_q <= 1'b0;
      half_q <= 1'b0;
      permit_q <= 1'b0;
    end else begin
      dwc_q <= delayed_write_clock_i;
      if (dwc_rise) begin
        half_q <= ~half_q;
      end
      permit_q <= dwc_rise & half_q;
    end
  end

  // bit position within the current word
  assign data_shift = shift_pulse_i & ~check_word_cycle_i
                      & ~parity_bit_cycle_i;
  assign last_bit = data_shift && bits_q == LAST_BIT;
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bits_q <= 4'h0;
      started_q <= 1'b0;
    end else if (init || subsector_start_i) begin
      bits_q <= 4'h0;
      started_q <= 1'b0;
    end else if (data_shift) begin
      bits_q <= bits_q + 4'h1;
      started_q <= 1'b1;
    end
  end

  // inhibit window near word boundaries and during check cycles
  always_comb begin
    bitwin = 1'b0;
    if (write_op_q) begin
      bitwin = bits_q >= WR_INHIBIT_BIT
               || (bits_q == 4'h0 && started_q);
    end else if (read_op_q) begin
      bitwin = bits_q >= RD_INHIBIT_BIT
               || (bits_q < RD_RESUME_BIT && started_q);
    end
  end
  assign inhib = bitwin | check_word_cycle_i | parity_bit_cycle_i
                 | subsector_end_interval_i;
  // go_wr and go_rd start no strobe while software is reinitialising the block
  assign go_wr = permit_q & write_op_q & reg_full_q & ~full
                 & ~inhib & ~bflp_q & ~init;
  assign go_rd = permit_q & read_op_q & ~empty & ~reg_full_q
                 & ~inhib & ~rsfb_q & ~init;

  // transfer strobes, one clock wide each
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bflp_q <= 1'b0;
      rsfb_q <= 1'b0;
      drs_q <= 1'b0;
      buffer_load_n_q <= 1'b0;
      shift_register_load_q <= 1'b0;
    end else begin
      bflp_q <= go_wr;
      rsfb_q <= go_rd;
      drs_q <= dat_wr | go_rd;
      buffer_load_n_q <= go_wr | deser_ld;
      shift_register_load_q <= do_shift_register_load;
    end
  end

  // register full flag; init restarts the transfer, so it beats a strobe
  // still in flight; otherwise a set outranks a clear in the same clock
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_full_q <= 1'b0;
    end else if (init) begin
      reg_full_q <= 1'b0;
    end else if (dat_wr || rsfb_q) begin
      reg_full_q <= 1'b1;
    end else if (bflp_q || dat_rd) begin
      reg_full_q <= 1'b0;
    end
  end

  // processor data register
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      data_q <= WORD_RESET;
    end else if (dat_wr) begin
      if (avs_byteenable_i[0]) begin
        data_q[7:0] <= avs_writedata_i[7:0];
      end
      if (avs_byteenable_i[1]) begin
        data_q[15:8] <= avs_writedata_i[15:8];
      end
    end else if (go_rd) begin
      data_q <= mem_q[rd_ptr_q];
    end
  end

  // serializer reloads at go and after each sixteenth bit
  assign do_shift_register_load = write_op_q & ~empty & ~(init | subsector_start_i)
                   & (write_sequence_go_i | last_bit);
  assign deser_word = {sr_q[14:0], read_bit_i};
  assign deser_ld = read_op_q & last_bit;
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sr_q <= WORD_RESET;
    end else if (do_shift_register_load) begin
      sr_q <= mem_q[rd_ptr_q];
    end else if (data_shift && write_op_q) begin
      sr_q <= {sr_q[14:0], 1'b0};
    end else if (data_shift) begin
      sr_q <= deser_word;
    end
  end

  // word buffer; reads leave the stored words in place
  always_ff @(posedge sys_clk_i) begin
    if (go_wr) begin
      mem_q[wr_ptr_q] <= data_q;
    end else if (deser_ld) begin
      mem_q[wr_ptr_q] <= deser_word;
    end
  end

  // pointers restart at init so diagnostic reread starts at word 0
  assign inc = go_wr | deser_ld;
  assign dec = do_shift_register_load | go_rd;
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_ptr_q <= 4'h0;
      rd_ptr_q <= 4'h0;
    end else if (init) begin
      wr_ptr_q <= 4'h0;
      rd_ptr_q <= 4'h0;
    end else begin
      if (inc) begin
        wr_ptr_q <= ptr_next(wr_ptr_q);
      end
      if (dec) begin
        rd_ptr_q <= ptr_next(rd_ptr_q);
      end
    end
  end

  // occupancy counter: 0F empty, 10 one word, 1F sixteen words
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_q <= CNT_EMPTY;
    end else if (init) begin
      // full preload only for a diagnostic read, never for a write
      cnt_q <= (avs_writedata_i[CTRL_DIAG_SEL]
                && avs_writedata_i[CTRL_READ_OP]
                && !avs_writedata_i[CTRL_WRITE_OP]) ? CNT_FULL
                                                    : CNT_EMPTY;
    end else if (inc && !dec) begin
      cnt_q <= cnt_q + 5'h01;
    end else if (dec && !inc) begin
      cnt_q <= cnt_q - 5'h01;
    end
  end

  // check word and parity follow the data bits
  dwbtc_check_gen u_check (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .clear_i(init | subsector_start_i),
    .shift_i(shift_pulse_i & ~parity_bit_cycle_i),
    .bit_i(write_op_q ? sr_q[15] : read_bit_i),
    .emit_i(check_word_cycle_i & write_op_q),
    .crc_o(crc),
    .parity_o(parity)
  );

  // serial write data, one clock behind the line state
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wdat_q <= 1'b0;
    end else if (check_word_cycle_i) begin
      wdat_q <= crc[15];
    end else if (parity_bit_cycle_i) begin
      wdat_q <= parity;
    end else begin
      wdat_q <= sr_q[15];
    end
  end

  // status flags registered so every output leaves a flip-flop
  logic full_q, empty_q, inhib_q;
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      full_q <= 1'b0;
      empty_q <= 1'b1;
      inhib_q <= 1'b0;
    end else begin
      full_q <= full;
      empty_q <= empty;
      inhib_q <= inhib;
    end
  end

  assign avs_readdata_o = rdata_q;
  assign avs_waitrequest_o = ~ack_q;
  assign write_data_o = wdat_q;
  assign buffer_load_from_processor_n_o = ~bflp_q;
  assign register_set_from_buffer_n_o = ~rsfb_q;
  assign data_register_set_o = drs_q;
  assign buffer_load_n_o = ~buffer_load_n_q;
  assign shift_register_load_o = shift_register_load_q;
  assign buffer_full_o = full_q;
  assign buffer_full_n_o = ~full_q;
  assign buffer_empty_n_o = ~empty_q;
  assign register_full_flag_o = reg_full_q;
  assign strobe_inhibit_n_o = ~inhib_q;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  a_permit_pace: assert property (
    permit_q |-> $past(dwc_rise) && $past(half_q))
    else $error("permit not on a second clock rise");
  a_strobe_per_xfer: assert property (
    dat_wr |=> drs_q ##1 !drs_q)
    else $error("register set missing for output transfer");
  a_wr_bit_window: assert property (
    bflp_q |-> $past(bits_q) < WR_INHIBIT_BIT)
    else $error("buffer load inside word end window");
  a_full_hold: assert property (
    bflp_q |-> $past(cnt_q) != CNT_FULL)
    else $error("buffer load while full");
  a_cycle_hold: assert property (
    (bflp_q || rsfb_q) |-> !$past(check_word_cycle_i
      || parity_bit_cycle_i || subsector_end_interval_i))
    else $error("strobe during check or end interval");
  a_deser_store: assert property (
    deser_ld && !init |=> buffer_load_n_q
      && cnt_q == $past(cnt_q) + 5'h01 - 5'($past(go_rd)))
    else $error("assembled word not stored");
  a_flag_after_set: assert property (
    rsfb_q && !init |=> reg_full_q && !rsfb_q)
    else $error("register full not set after strobe");
  a_take_clears: assert property (
    dat_rd |=> !reg_full_q)
    else $error("input transfer left register full");
  a_rd_bit_window: assert property (
    rsfb_q |-> $past(bits_q) < RD_INHIBIT_BIT)
    else $error("register strobe inside word end window");
  a_init_preload: assert property (
    init |=> cnt_q == (($past(avs_writedata_i[CTRL_DIAG_SEL])
                         && $past(avs_writedata_i[CTRL_READ_OP])
                         && !$past(avs_writedata_i[CTRL_WRITE_OP]))
                        ? CNT_FULL : CNT_EMPTY) && !reg_full_q)
    else $error("init preload wrong");
  a_full_decode: assert property (
    cnt_q == CNT_FULL |=> buffer_full_o && !buffer_full_n_o)
    else $error("full flag not raised");

  c_write_load: cover property (bflp_q ##[1:200] shift_register_load_q);
  c_read_take: cover property (rsfb_q ##[1:50] dat_rd);
  c_fill_up: cover property (full && write_op_q);
endmodule : dwbtc_top

// ==== pkg/dwbtc_pkg.sv ====
package dwbtc_pkg;
  // register word indexes on the avalon slave (byte address = index * 4)
  localparam logic [1:0] ADDR_CTRL = 2'h0;
  localparam logic [1:0] ADDR_STAT = 2'h1;
  localparam logic [1:0] ADDR_DATA = 2'h2;
  localparam logic [1:0] ADDR_CHECK = 2'h3;
  // control register field positions
  localparam int CTRL_WRITE_OP = 0;
  localparam int CTRL_READ_OP = 1;
  localparam int CTRL_DIAG_SEL = 2;
  // status register field positions
  localparam int STAT_CNT_LSB = 0;
  localparam int STAT_FULL = 5;
  localparam int STAT_EMPTY = 6;
  localparam int STAT_REG_FULL = 7;
  // occupancy counter preloads and decodes
  localparam logic [4:0] CNT_EMPTY = 5'h0F;
  localparam logic [4:0] CNT_FULL = 5'h1F;
  // bit positions in a word where strobes are held off
  localparam logic [3:0] WR_INHIBIT_BIT = 4'hD;
  localparam logic [3:0] RD_INHIBIT_BIT = 4'hE;
  localparam logic [3:0] RD_RESUME_BIT = 4'h2;
  localparam logic [3:0] LAST_BIT = 4'hF;
  // check word generator polynomial x^16+x^15+x^2+1
  localparam logic [15:0] CHECK_POLY = 16'h8005;
  localparam logic [15:0] WORD_RESET = 16'h0000;
endpackage : dwbtc_pkg

// ==== hdl/dwbtc_check_gen.sv ====
`timescale 1ns/1ps
module dwbtc_check_gen
  import dwbtc_pkg::*;
(
  input wire logic sys_clk_i, // 100 MHz clock
  input wire logic sys_rst_i, // async reset, active high
  input wire logic clear_i, // restart for a new subsector
  input wire logic shift_i, // one bit passes the line
  input wire logic bit_i, // data bit on the line
  input wire logic emit_i, // shift the check word out
  output logic [15:0] crc_o, // running check word
  output logic parity_o // odd parity bit to send
);
  logic [15:0] crc_q;
  logic odd_q;
  logic fb;

  // feedback on each shifted bit unless emitting; emitting just drains the word
  assign fb = bit_i ^ crc_q[15];

  // cyclic check word register
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      crc_q <= WORD_RESET;
    end else if (clear_i) begin
      crc_q <= WORD_RESET;
    end else if (shift_i && emit_i) begin
      crc_q <= {crc_q[14:0], 1'b0};
    end else if (shift_i) begin
      crc_q <= {crc_q[14:0], 1'b0} ^ (fb ? CHECK_POLY : WORD_RESET);
    end
  end

  // count ones on the line, check word bits included
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      odd_q <= 1'b0;
    end else if (clear_i) begin
      odd_q <= 1'b0;
    end else if (shift_i) begin
      odd_q <= odd_q ^ (emit_i ? crc_q[15] : bit_i);
    end
  end

  assign crc_o = crc_q;
  assign parity_o = ~odd_q;
endmodule : dwbtc_check_gen

// ==== tb/dwbtc_partner.sv ====
`timescale 1ns/1ps
// far side stand-in: disc timing clock and deserializer bit feed
module dwbtc_partner (
  input wire logic sys_clk_i, // 100 MHz clock
  input wire logic sys_rst_i, // async reset, active high
  input wire logic start_i, // pulse, begin a burst of bits
  input wire logic [15:0] word_i, // bits to send, msb first
  input wire logic [4:0] count_i, // number of bit pulses
  output logic delayed_write_clock_o, // free running timing clock
  output logic shift_pulse_o, // one bit passes the head
  output logic read_bit_o // bit from the disc
);
  logic [1:0] ph_q;
  logic [3:0] idx_q;
  logic [4:0] left_q;
  // timing clock runs free, one rise every 8 cycles
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ph_q <= 2'h0;
      delayed_write_clock_o <= 1'b0;
    end else begin
      ph_q <= ph_q + 2'h1;
      if (ph_q == 2'h3) begin
        delayed_write_clock_o <= !delayed_write_clock_o;
      end
    end
  end
  // bit feed; idle line toggles so a stale bit is never mistaken
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      idx_q <= 4'h0;
      left_q <= 5'h00;
      shift_pulse_o <= 1'b0;
      read_bit_o <= 1'b0;
    end else begin
      shift_pulse_o <= 1'b0;
      if (start_i) begin
        idx_q <= 4'h0;
        left_q <= count_i;
      end else if (left_q != 5'h00) begin
        read_bit_o <= word_i[4'hF - idx_q];
        if (ph_q == 2'h2) begin
          shift_pulse_o <= 1'b1;
          idx_q <= idx_q + 4'h1;
          left_q <= left_q - 5'h01;
        end
      end else begin
        read_bit_o <= !read_bit_o;
      end
    end
  end
endmodule : dwbtc_partner

// ==== tb/dwbtc_bench.sv ====
`timescale 1ns/1ps
module dwbtc_bench;
  import dwbtc_pkg::*;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [1:0] adr = 2'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic wreq;
  logic dwc, shp, rbit;
  logic sstart = 1'b0;
  logic go = 1'b0;
  logic ccyc = 1'b0;
  logic endi = 1'b0;
  logic pstart = 1'b0;
  logic [15:0] pword = 16'hA5C3;
  logic [4:0] pcount = 5'h12;
  logic bl_n, rsb_n, drs, bln_n, srl, full, full_n, empty_n, rfull, inh_n;
  logic [31:0] q;
  int err_count = 0;
  int tests_run = 0;
  int bl_cnt = 0;
  int drs_cnt = 0;
  int rsb_cnt = 0;
  int bln_cnt = 0;
  int srl_cnt = 0;
  int bln0 = 0;
  int rsb0 = 0;

  // 100 MHz clock
  always #5 sys_clk_i = !sys_clk_i;

  dwbtc_top uut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdat), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
    .delayed_write_clock_i(dwc), .subsector_start_i(sstart),
    .write_sequence_go_i(go), .shift_pulse_i(shp), .read_bit_i(rbit),
    .check_word_cycle_i(ccyc), .parity_bit_cycle_i(1'b0),
    .subsector_end_interval_i(endi), .write_data_o(),
    .buffer_load_from_processor_n_o(bl_n),
    .register_set_from_buffer_n_o(rsb_n), .data_register_set_o(drs),
    .buffer_load_n_o(bln_n), .shift_register_load_o(srl),
    .buffer_full_o(full), .buffer_full_n_o(full_n),
    .buffer_empty_n_o(empty_n), .register_full_flag_o(rfull),
    .strobe_inhibit_n_o(inh_n));

  dwbtc_partner far (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .start_i(pstart), .word_i(pword), .count_i(pcount),
    .delayed_write_clock_o(dwc), .shift_pulse_o(shp), .read_bit_o(rbit));

  // strobe tallies, each strobe lasts one cycle
  always @(posedge sys_clk_i) begin
    if (!sys_rst_i) begin
      if (bl_n === 1'b0) bl_cnt++;
      if (drs === 1'b1) drs_cnt++;
      if (rsb_n === 1'b0) rsb_cnt++;
      if (bln_n === 1'b0) bln_cnt++;
      if (srl === 1'b1) srl_cnt++;
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, exp, input string m);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // one avalon access; request held until waitrequest seen low
  task automatic bus(input logic [1:0] a, input logic w,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    adr <= a;
    wr <= w;
    rd <= !w;
    wdat <= d;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (wreq !== 1'b0 && n < 400);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 400) begin
      err_count++;
      $display("BAD %0t bus access timed out", $time);
      finish_test();
    end
  endtask : bus

  task automatic stat(input logic [31:0] e, input string m);
    bus(ADDR_STAT, 1'b0, 32'h0);
    chk(q, e, m);
  endtask : stat

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : idle

  // hang guard
  initial begin
    idle(50000);
    err_count++;
    $display("BAD %0t run timed out", $time);
    finish_test();
  end

  // main sequence
  initial begin
    idle(12);
    sys_rst_i <= 1'b0;
    stat(32'h0000004F, "reset status");
    chk({31'h0, empty_n}, 32'h0, "empty pin");
    bus(ADDR_CTRL, 1'b1, 32'h1);
    stat(32'h0000004F, "write init");
    for (int i = 0; i < 16; i++) begin
      bus(ADDR_DATA, 1'b1, 32'h1000 + i);
    end
    idle(40);
    chk(bl_cnt, 16, "buffer loads");
    chk(drs_cnt, 16, "register sets");
    stat(32'h0000003F, "full status");
    chk({30'h0, full, full_n}, 32'h2, "full pins");
    // one more word while full must stay in the register
    bus(ADDR_DATA, 1'b1, 32'h2222);
    idle(40);
    chk(bl_cnt, 16, "load while full");
    ccyc <= 1'b1;
    @(posedge sys_clk_i);
    go <= 1'b1;
    @(posedge sys_clk_i);
    go <= 1'b0;
    idle(40);
    chk(srl_cnt, 1, "serializer load");
    chk(bl_cnt, 16, "load in check cycle");
    stat(32'h0000009E, "one word out");
    ccyc <= 1'b0;
    endi <= 1'b1;
    idle(40);
    chk(bl_cnt, 16, "load in end interval");
    chk({31'h0, inh_n}, 32'h0, "inhibit pin");
    // end interval kept on so no strobe races the mode changes
    bus(ADDR_CTRL, 1'b1, 32'h6);
    stat(32'h0000003F, "diagnostic init");
    endi <= 1'b0;
    bus(ADDR_DATA, 1'b0, 32'h0);
    endi <= 1'b1;
    chk(q, 32'h00001000, "diagnostic reread");
    bus(ADDR_CTRL, 1'b1, 32'h2);
    stat(32'h0000004F, "read init");
    bln0 = bln_cnt;
    rsb0 = rsb_cnt;
    @(posedge sys_clk_i);
    sstart <= 1'b1;
    pstart <= 1'b1;
    endi <= 1'b0;
    @(posedge sys_clk_i);
    sstart <= 1'b0;
    pstart <= 1'b0;
    idle(100);
    chk(bln_cnt - bln0, 1, "disc word load");
    chk(rsb_cnt - rsb0, 1, "register strobe");
    bus(ADDR_DATA, 1'b0, 32'h0);
    chk(q, 32'h0000A5C3, "read word");
    stat(32'h0000004F, "after input transfer");
    finish_test();
  end
endmodule : dwbtc_bench
